// >>> core/lte_error_log.sv
// Logical/transport error detect register with event outputs
`timescale 1ns/100ps
`include "lte_cfg.svh"
module lte_error_log (
	input  wire logic                   i_mclk,
	input  wire logic                   i_srst,
	input  wire logic                   i_psel,
	input  wire logic                   i_penable,
	input  wire logic                   i_pwrite,
	input  wire logic [`LTE_AW-1:0]     i_paddr,
	input  wire logic [`LTE_DW-1:0]     i_pwdata,
	output logic                        o_pready,
	output logic [`LTE_DW-1:0]          o_prdata,
	output logic                        o_pslverr,
	input  wire logic [`LTE_NUM_LS-1:0] i_load_store_unit_err_rsp,
	input  wire logic [`LTE_NUM_LS-1:0] i_load_store_unit_bad_field,
	input  wire logic [`LTE_NUM_LS-1:0] i_load_store_unit_rsp_timeout,
	input  wire logic [`LTE_NUM_LS-1:0] i_load_store_unit_unexpected_rsp,
	input  wire logic                   i_message_transmit_unit_err_rsp,
	input  wire logic                   i_message_transmit_unit_bad_field,
	input  wire logic                   i_message_transmit_unit_rsp_timeout,
	input  wire logic                   i_message_transmit_unit_unexpected_rsp,
	input  wire logic                   i_message_receive_unit_bad_format,
	input  wire logic                   i_message_receive_unit_bad_field,
	input  wire logic                   i_message_receive_unit_req_timeout,
	input  wire logic                   i_message_receive_unit_queue_block,
	input  wire logic                   i_memory_access_unit_bad_field,
	input  wire logic                   i_memory_access_unit_unsupported,
	input  wire logic                   i_memory_access_unit_dma_block,
	input  wire logic                   i_service_req,
	output logic                        o_error_event,
	output logic                        o_critical_event,
	output logic                        o_service_event,
	output logic                        o_error_pending,
	output logic                        o_critical_pending
);
	// ----------------------------------------
	// State and bus front end
	// ----------------------------------------
	localparam lte_pkg::lte_core_s RST = '{
		flags:     `LTE_DETECT_RST,
		crit_mask: `LTE_CLASS_RST,
		default:   '0
	};

	lte_pkg::lte_core_s    r;
	lte_pkg::lte_core_s    next_r;
	logic [`LTE_DW-1:0]    hw_set;
	logic [`LTE_DW-1:0]    clr;
	logic [`LTE_DW-1:0]    new_set;
	logic                  det_wr;
	logic                  cls_wr;
	logic                  sts_wr;
	logic                  any_ev;

	lte_reg_if regs ();

	lte_apb_front u_front (
		.i_mclk    (i_mclk),
		.i_srst    (i_srst),
		.i_psel    (i_psel),
		.i_penable (i_penable),
		.i_pwrite  (i_pwrite),
		.i_paddr   (i_paddr),
		.i_pwdata  (i_pwdata),
		.o_pready  (o_pready),
		.o_prdata  (o_prdata),
		.o_pslverr (o_pslverr),
		.regs      (regs.front)
	);

	// ----------------------------------------
	// Error capture and register file
	// ----------------------------------------
	always_comb begin
		next_r = r;
		hw_set = `LTE_ZERO;
		hw_set[`LTE_B_IO_RSP]  = |i_load_store_unit_err_rsp; // [R1]
		hw_set[`LTE_B_MSG_RSP] = i_message_transmit_unit_err_rsp; // [R2]
		hw_set[`LTE_B_FORMAT]  = i_message_receive_unit_bad_format; // [R3]
		hw_set[`LTE_B_DECODE]  = (|i_load_store_unit_bad_field)
			| i_message_transmit_unit_bad_field // [R4]
			| i_memory_access_unit_bad_field
			| i_message_receive_unit_bad_field; // [R5]
		hw_set[`LTE_B_REQ_TMO] = i_message_receive_unit_req_timeout; // [R6]
		hw_set[`LTE_B_RSP_TMO] = (|i_load_store_unit_rsp_timeout)
			| i_message_transmit_unit_rsp_timeout; // [R7]
		hw_set[`LTE_B_UNEXP]   = (|i_load_store_unit_unexpected_rsp)
			| i_message_transmit_unit_unexpected_rsp; // [R8]
		hw_set[`LTE_B_UNSUP]   = i_memory_access_unit_unsupported; // [R9]
		hw_set[`LTE_B_QBLOCK]  = i_message_receive_unit_queue_block; // [R10]
		hw_set[`LTE_B_DMABLK]  = i_memory_access_unit_dma_block; // [R11]

		det_wr = regs.wr_stb && (regs.sel == lte_pkg::LTE_REG_DETECT);
		cls_wr = regs.wr_stb && (regs.sel == lte_pkg::LTE_REG_CLASS);
		sts_wr = regs.wr_stb && (regs.sel == lte_pkg::LTE_REG_STATUS);

		// Only zeros clear; ones written leave the flag as it is
		clr = det_wr ? (~regs.wdata & `LTE_FLAG_MASK) : `LTE_ZERO; // [R12] [R18]
		// Set is ORed after the clear so a same-cycle error is never lost
		next_r.flags = ((r.flags & ~clr) | hw_set) & `LTE_FLAG_MASK; // [R19] [R13]

		if (cls_wr) begin
			next_r.crit_mask = regs.wdata & `LTE_FLAG_MASK;
			next_r.svc_en    = regs.wdata[`LTE_B_SVC_EN];
		end

		// Error and critical events fire only on a fresh flag, not on repeats of a held one
		new_set        = hw_set & ~r.flags;
		next_r.err_ev  = |(new_set & ~r.crit_mask); // [R15]
		next_r.crit_ev = |(new_set & r.crit_mask); // [R16]
		next_r.svc_ev  = i_service_req & r.svc_en; // [R17]

		// Saturating count of cycles with an error or critical event; a write to status restarts it
		any_ev = next_r.err_ev | next_r.crit_ev;
		if (sts_wr) begin
			next_r.err_cnt = any_ev ? `LTE_CNT_ONE : '0;
		end else if (any_ev && (r.err_cnt != `LTE_CNT_MAX)) begin
			next_r.err_cnt = r.err_cnt + `LTE_CNT_ONE;
		end

		next_r.pending      = |next_r.flags;
		next_r.crit_pending = |(next_r.flags & next_r.crit_mask);

		regs.rdata = `LTE_ZERO;
		if (regs.sel == lte_pkg::LTE_REG_DETECT) begin
			regs.rdata = r.flags & `LTE_FLAG_MASK; // [R13]
		end else if (regs.sel == lte_pkg::LTE_REG_CLASS) begin
			regs.rdata = r.crit_mask;
			regs.rdata[`LTE_B_SVC_EN] = r.svc_en;
		end else if (regs.sel == lte_pkg::LTE_REG_STATUS) begin
			regs.rdata[`LTE_B_PEND]      = r.pending;
			regs.rdata[`LTE_B_CRIT_PEND] = r.crit_pending;
			regs.rdata[`LTE_CNT_LSB +: `LTE_CNT_W] = r.err_cnt;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			r <= RST; // [R14]
		end else begin
			r <= next_r;
		end
	end

	assign o_error_event      = r.err_ev;
	assign o_critical_event   = r.crit_ev;
	assign o_service_event    = r.svc_ev;
	assign o_error_pending    = r.pending;
	assign o_critical_pending = r.crit_pending;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_detect_write;
		regs.wr_stb && (regs.sel == lte_pkg::LTE_REG_DETECT);
	endsequence

	sequence s_read_detect;
		i_psel && i_penable && !o_pready && !i_pwrite
			&& (regs.sel == lte_pkg::LTE_REG_DETECT);
	endsequence

	property p_io_rsp;
		@(posedge i_mclk) disable iff (i_srst)
		(|i_load_store_unit_err_rsp) |=> r.flags[`LTE_B_IO_RSP];
	endproperty
	a_io_rsp: assert property (p_io_rsp) // [R1]
		else $error("io error response flag not set");

	property p_msg_rsp;
		@(posedge i_mclk) disable iff (i_srst)
		i_message_transmit_unit_err_rsp |=> r.flags[`LTE_B_MSG_RSP];
	endproperty
	a_msg_rsp: assert property (p_msg_rsp) // [R2]
		else $error("message error response flag not set");

	property p_format;
		@(posedge i_mclk) disable iff (i_srst)
		i_message_receive_unit_bad_format |=> r.flags[`LTE_B_FORMAT];
	endproperty
	a_format: assert property (p_format) // [R3]
		else $error("bad message format flag not set");

	property p_decode_rsp;
		@(posedge i_mclk) disable iff (i_srst)
		((|i_load_store_unit_bad_field) || i_message_transmit_unit_bad_field)
			|=> r.flags[`LTE_B_DECODE] && o_error_pending;
	endproperty
	a_decode_rsp: assert property (p_decode_rsp) // [R4]
		else $error("illegal response field flag not set");

	property p_decode_req;
		@(posedge i_mclk) disable iff (i_srst)
		(i_memory_access_unit_bad_field || i_message_receive_unit_bad_field)
			|=> r.flags[`LTE_B_DECODE];
	endproperty
	a_decode_req: assert property (p_decode_req) // [R5]
		else $error("illegal request field flag not set");

	property p_req_tmo;
		@(posedge i_mclk) disable iff (i_srst)
		i_message_receive_unit_req_timeout |=> r.flags[`LTE_B_REQ_TMO];
	endproperty
	a_req_tmo: assert property (p_req_tmo) // [R6]
		else $error("message request timeout flag not set");

	property p_rsp_tmo;
		@(posedge i_mclk) disable iff (i_srst)
		((|i_load_store_unit_rsp_timeout) || i_message_transmit_unit_rsp_timeout)
			|=> r.flags[`LTE_B_RSP_TMO];
	endproperty
	a_rsp_tmo: assert property (p_rsp_tmo) // [R7]
		else $error("response timeout flag not set");

	property p_unexp;
		@(posedge i_mclk) disable iff (i_srst)
		((|i_load_store_unit_unexpected_rsp) || i_message_transmit_unit_unexpected_rsp)
			|=> r.flags[`LTE_B_UNEXP];
	endproperty
	a_unexp: assert property (p_unexp) // [R8]
		else $error("unexpected response flag not set");

	property p_unsup;
		@(posedge i_mclk) disable iff (i_srst)
		i_memory_access_unit_unsupported |=> r.flags[`LTE_B_UNSUP];
	endproperty
	a_unsup: assert property (p_unsup) // [R9]
		else $error("unsupported request flag not set");

	property p_qblock;
		@(posedge i_mclk) disable iff (i_srst)
		i_message_receive_unit_queue_block |=> r.flags[`LTE_B_QBLOCK];
	endproperty
	a_qblock: assert property (p_qblock) // [R10]
		else $error("receive queue block flag not set");

	property p_dmablk;
		@(posedge i_mclk) disable iff (i_srst)
		i_memory_access_unit_dma_block |=> r.flags[`LTE_B_DMABLK];
	endproperty
	a_dmablk: assert property (p_dmablk) // [R11]
		else $error("dma access block flag not set");

	property p_clear_only_by_zero;
		@(posedge i_mclk) disable iff (i_srst)
		(!$past(i_srst) && ((($past(r.flags) & ~r.flags)) != `LTE_ZERO))
			|-> $past(det_wr);
	endproperty
	a_clear_only_by_zero: assert property (p_clear_only_by_zero) // [R12]
		else $error("flag cleared without a zero write");

	property p_reserved_zero;
		@(posedge i_mclk) disable iff (i_srst)
		s_read_detect |=> o_pready && ((o_prdata & ~`LTE_FLAG_MASK) == `LTE_ZERO)
			##1 !o_pready;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) // [R13]
		else $error("reserved detect bit read as one");

	property p_reset_clear;
		@(posedge i_mclk) disable iff (i_srst)
		$past(i_srst) |-> (r.flags == `LTE_ZERO) && !o_error_event
			&& !o_critical_event && !o_service_event && !o_pready;
	endproperty
	a_reset_clear: assert property (p_reset_clear) // [R14]
		else $error("state not zero after reset");

	property p_error_event;
		@(posedge i_mclk) disable iff (i_srst)
		((hw_set & ~r.flags & ~r.crit_mask) != `LTE_ZERO)
			|=> o_error_event && o_error_pending;
	endproperty
	a_error_event: assert property (p_error_event) // [R15]
		else $error("error status event missing");

	property p_critical_event;
		@(posedge i_mclk) disable iff (i_srst)
		((hw_set & ~r.flags & r.crit_mask) != `LTE_ZERO)
			|=> o_critical_event && o_critical_pending;
	endproperty
	a_critical_event: assert property (p_critical_event) // [R16]
		else $error("critical error event missing");

	property p_no_spurious_event;
		@(posedge i_mclk) disable iff (i_srst)
		((hw_set & ~r.flags) == `LTE_ZERO) |=> !o_error_event && !o_critical_event;
	endproperty
	a_no_spurious_event: assert property (p_no_spurious_event) // [R15]
		else $error("error event without a new flag");

	property p_service_event;
		@(posedge i_mclk) disable iff (i_srst)
		(i_service_req && r.svc_en) |=> o_service_event;
	endproperty
	a_service_event: assert property (p_service_event) // [R17]
		else $error("servicing event missing");

	property p_service_quiet;
		@(posedge i_mclk) disable iff (i_srst)
		(!i_service_req || !r.svc_en) |=> !o_service_event;
	endproperty
	a_service_quiet: assert property (p_service_quiet) // [R17]
		else $error("servicing event while not requested");

	property p_sticky;
		@(posedge i_mclk) disable iff (i_srst)
		(!det_wr || (regs.wdata == ~`LTE_ZERO))
			|=> ((r.flags & $past(r.flags)) == $past(r.flags));
	endproperty
	a_sticky: assert property (p_sticky) // [R18]
		else $error("flag dropped without a zero write");

	property p_set_wins;
		@(posedge i_mclk) disable iff (i_srst)
		(s_detect_write and ((hw_set & clr) != `LTE_ZERO))
			|=> ((r.flags & $past(hw_set)) == $past(hw_set));
	endproperty
	a_set_wins: assert property (p_set_wins) // [R19]
		else $error("clear overrode a same-cycle error");

	// Checked while reset is held, so no disable here
	property p_reset_outputs;
		@(posedge i_mclk)
		i_srst |=> (r.flags == `LTE_ZERO) && !o_error_pending && !o_critical_pending
			&& (r.err_cnt == '0);
	endproperty
	a_reset_outputs: assert property (p_reset_outputs) // [R14]
		else $error("state not cleared by reset");

	property p_pending_level;
		@(posedge i_mclk) disable iff (i_srst)
		o_error_pending == (r.flags != `LTE_ZERO);
	endproperty
	a_pending_level: assert property (p_pending_level) // [R15]
		else $error("error pending does not follow the flags");

	property p_crit_pending_level;
		@(posedge i_mclk) disable iff (i_srst)
		o_critical_pending == ((r.flags & r.crit_mask) != `LTE_ZERO);
	endproperty
	a_crit_pending_level: assert property (p_crit_pending_level) // [R16]
		else $error("critical pending does not follow the flags");

	property p_count_step;
		@(posedge i_mclk) disable iff (i_srst)
		(any_ev && !sts_wr && (r.err_cnt != `LTE_CNT_MAX))
			|=> (r.err_cnt == $past(r.err_cnt) + `LTE_CNT_ONE);
	endproperty
	a_count_step: assert property (p_count_step) // [R15]
		else $error("event count did not advance");
endmodule

// >>> shared/lte_cfg.svh
// Constants of the logical/transport error log
// Function
// R1 - Load/store error response sets bit 31
// R2 - Transmit unit error response sets bit 30
// R3 - Bad message size or segment sets 28
// R4 - Illegal response fields set bit 27
// R5 - Illegal request fields also set 27
// R6 - Missing message request timeout sets 25
// R7 - Missing response timeout sets bit 24
// R8 - Unmatched response sets bit 23
// R9 - Unsupported transaction type sets bit 22
// R10 - Receive queue access block sets 7
// R11 - Blocked DMA access sets bit 6
// R12 - Flag cleared only by writing zero
// R13 - Reserved bits read-only, read zero
// R14 - Every field zero after reset
// R15 - Error status event on run-time error
// R16 - Critical error event on critical error
// R17 - Servicing event asks processor for attention
// R18 - Flags stick; writing one changes nothing
// R19 - Set wins over same-cycle clear
`ifndef LTE_CFG_SVH
`define LTE_CFG_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define LTE_AW 12
`define LTE_DW 32
`define LTE_NUM_LS 4
`define LTE_CNT_W 16

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define LTE_OFS_DETECT 12'h000
`define LTE_OFS_CLASS 12'h004
`define LTE_OFS_STATUS 12'h008

// ----------------------------------------
// Detect register fields
// ----------------------------------------
`define LTE_B_IO_RSP 31
`define LTE_B_MSG_RSP 30
`define LTE_B_FORMAT 28
`define LTE_B_DECODE 27
`define LTE_B_REQ_TMO 25
`define LTE_B_RSP_TMO 24
`define LTE_B_UNEXP 23
`define LTE_B_UNSUP 22
`define LTE_B_QBLOCK 7
`define LTE_B_DMABLK 6
`define LTE_FLAG_MASK 32'hdbc0_00c0

// ----------------------------------------
// Class and status fields, reset values
// ----------------------------------------
`define LTE_B_SVC_EN 0
`define LTE_B_PEND 0
`define LTE_B_CRIT_PEND 1
`define LTE_CNT_LSB 16
`define LTE_CNT_MAX 16'hffff
`define LTE_CNT_ONE 16'h0001
`define LTE_DETECT_RST 32'h0000_0000
`define LTE_CLASS_RST 32'h0000_0000
`define LTE_ZERO 32'h0000_0000

`endif

// >>> shared/lte_pkg.sv
// Types of the logical/transport error log
`include "lte_cfg.svh"
package lte_pkg;
	typedef enum logic [1:0] {
		LTE_REG_DETECT,
		LTE_REG_CLASS,
		LTE_REG_STATUS,
		LTE_REG_NONE
	} lte_reg_e;

	typedef struct packed {
		logic                 pready;
		logic                 pslverr;
		logic [`LTE_DW-1:0]   prdata;
	} lte_front_s;

	typedef struct packed {
		logic [`LTE_DW-1:0]    flags;
		logic [`LTE_DW-1:0]    crit_mask;
		logic                  svc_en;
		logic [`LTE_CNT_W-1:0] err_cnt;
		logic                  err_ev;
		logic                  crit_ev;
		logic                  svc_ev;
		logic                  pending;
		logic                  crit_pending;
	} lte_core_s;
endpackage

// >>> shared/lte_reg_if.sv
// Register access strobes between bus front end and error log
`timescale 1ns/100ps
`include "lte_cfg.svh"
interface lte_reg_if;
	logic                wr_stb;
	lte_pkg::lte_reg_e   sel;
	logic [`LTE_DW-1:0]  wdata;
	logic [`LTE_DW-1:0]  rdata;

	modport front (output wr_stb, output sel, output wdata, input rdata);
	modport core  (input wr_stb, input sel, input wdata, output rdata);
endinterface

// >>> core/lte_apb_front.sv
// APB slave front end with one wait state
`timescale 1ns/100ps
`include "lte_cfg.svh"
module lte_apb_front (
	input  wire logic                i_mclk,
	input  wire logic                i_srst,
	input  wire logic                i_psel,
	input  wire logic                i_penable,
	input  wire logic                i_pwrite,
	input  wire logic [`LTE_AW-1:0]  i_paddr,
	input  wire logic [`LTE_DW-1:0]  i_pwdata,
	output logic                     o_pready,
	output logic [`LTE_DW-1:0]       o_prdata,
	output logic                     o_pslverr,
	lte_reg_if.front                 regs
);
	lte_pkg::lte_front_s r;
	lte_pkg::lte_front_s next_r;

	function automatic lte_pkg::lte_reg_e decode(input logic [`LTE_AW-1:0] a);
		if (a == `LTE_OFS_DETECT) begin
			decode = lte_pkg::LTE_REG_DETECT;
		end else if (a == `LTE_OFS_CLASS) begin
			decode = lte_pkg::LTE_REG_CLASS;
		end else if (a == `LTE_OFS_STATUS) begin
			decode = lte_pkg::LTE_REG_STATUS;
		end else begin
			decode = lte_pkg::LTE_REG_NONE;
		end
	endfunction

	// Read data is sampled one cycle before pready, so it is stable with it
	always_comb begin
		next_r       = r;
		regs.sel     = decode(i_paddr);
		regs.wdata   = i_pwdata;
		regs.wr_stb  = i_psel & i_penable & r.pready & i_pwrite;
		if (r.pready) begin
			next_r.pready  = 1'b0;
			next_r.pslverr = 1'b0;
			next_r.prdata  = `LTE_ZERO;
		end else if (i_psel && i_penable) begin
			next_r.pready  = 1'b1;
			next_r.pslverr = (regs.sel == lte_pkg::LTE_REG_NONE);
			next_r.prdata  = i_pwrite ? `LTE_ZERO : regs.rdata;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign o_pready  = r.pready;
	assign o_prdata  = r.prdata;
	assign o_pslverr = r.pslverr;
endmodule

// >>> bench/tb.sv
// Self-checking bench for the logical/transport error log
`timescale 1ns/100ps
`include "lte_cfg.svh"
module tb;
	// ----------------------------------------
	// Signals and model state
	// ----------------------------------------
	localparam int POS [27] = '{31, 31, 31, 31, 27, 27, 27, 27, 24, 24, 24, 24, 23, 23, 23, 23,
		30, 27, 24, 23, 28, 27, 25, 7, 27, 22, 6};
	logic                   i_mclk = 1'b0;
	logic                   i_srst = 1'b1;
	logic                   i_psel = 1'b0;
	logic                   i_penable = 1'b0;
	logic                   i_pwrite = 1'b0;
	logic [`LTE_AW-1:0]     i_paddr = '0;
	logic [`LTE_DW-1:0]     i_pwdata = '0;
	logic [26:0]            src = '0;
	logic                   i_service_req = 1'b0;
	logic                   o_pready;
	logic                   o_pslverr;
	logic [`LTE_DW-1:0]     o_prdata;
	logic                   o_error_event;
	logic                   o_critical_event;
	logic                   o_service_event;
	logic                   o_error_pending;
	logic                   o_critical_pending;
	logic [34:0]            apb_q [$];
	logic [2:0]             ev_q [$];
	logic [34:0]            ae;
	logic [2:0]             ee;
	logic [31:0]            flags = '0;
	logic [31:0]            mask = '0;
	logic                   svc_en = 1'b0;
	logic [15:0]            cnt = '0;
	logic [31:0]            r;
	logic [31:0]            r2;
	int                     miscompares = 0;
	int                     checks = 0;
	int                     cycles = 0;
	int                     seed = 39807;

	always #5 i_mclk = ~i_mclk;

	lte_error_log dut (
		.i_mclk                                 (i_mclk),
		.i_srst                                 (i_srst),
		.i_psel                                 (i_psel),
		.i_penable                              (i_penable),
		.i_pwrite                               (i_pwrite),
		.i_paddr                                (i_paddr),
		.i_pwdata                               (i_pwdata),
		.o_pready                               (o_pready),
		.o_prdata                               (o_prdata),
		.o_pslverr                              (o_pslverr),
		.i_load_store_unit_err_rsp              (src[3:0]),
		.i_load_store_unit_bad_field            (src[7:4]),
		.i_load_store_unit_rsp_timeout          (src[11:8]),
		.i_load_store_unit_unexpected_rsp       (src[15:12]),
		.i_message_transmit_unit_err_rsp        (src[16]),
		.i_message_transmit_unit_bad_field      (src[17]),
		.i_message_transmit_unit_rsp_timeout    (src[18]),
		.i_message_transmit_unit_unexpected_rsp (src[19]),
		.i_message_receive_unit_bad_format      (src[20]),
		.i_message_receive_unit_bad_field       (src[21]),
		.i_message_receive_unit_req_timeout     (src[22]),
		.i_message_receive_unit_queue_block     (src[23]),
		.i_memory_access_unit_bad_field         (src[24]),
		.i_memory_access_unit_unsupported       (src[25]),
		.i_memory_access_unit_dma_block         (src[26]),
		.i_service_req                          (i_service_req),
		.o_error_event                          (o_error_event),
		.o_critical_event                       (o_critical_event),
		.o_service_event                        (o_service_event),
		.o_error_pending                        (o_error_pending),
		.o_critical_pending                     (o_critical_pending)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	function automatic logic [31:0] to_flags(input logic [26:0] v);
		logic [31:0] f;
		f = '0;
		for (int k = 0; k < 27; k++) begin
			if (v[k]) begin
				f[POS[k]] = 1'b1;
			end
		end
		return f;
	endfunction

	// Model update for one cycle of error sources; only 0->1 flag changes pulse the error events
	task automatic note(input logic [26:0] v, input logic s);
		logic [31:0] nw;
		nw = to_flags(v) & ~flags;
		flags = flags | to_flags(v);
		if (nw != '0 && cnt != 16'hffff) begin
			cnt = cnt + 16'h0001;
		end
		if (nw != '0 || (s && svc_en)) begin
			ev_q.push_back({s & svc_en, |(nw & mask), |(nw & ~mask)});
		end
	endtask

	task automatic fire(input logic [26:0] v, input logic s);
		note(v, s);
		@(posedge i_mclk);
		src <= v;
		i_service_req <= s;
		@(posedge i_mclk);
		src <= '0;
		i_service_req <= 1'b0;
	endtask

	// Expectation is taken before the model sees the write
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        bad;
		bad = !(a inside {`LTE_OFS_DETECT, `LTE_OFS_CLASS, `LTE_OFS_STATUS});
		rd = '0;
		if (!wr && a == `LTE_OFS_DETECT) begin
			rd = flags;
		end
		if (!wr && a == `LTE_OFS_CLASS) begin
			rd = mask | {31'h0, svc_en};
		end
		if (!wr && a == `LTE_OFS_STATUS) begin
			rd = {cnt, 14'h0, |(flags & mask), |flags};
		end
		apb_q.push_back({|(flags & mask), |flags, bad, rd});
		if (wr && a == `LTE_OFS_DETECT) begin
			flags = flags & d;
		end
		if (wr && a == `LTE_OFS_CLASS) begin
			mask = d & `LTE_FLAG_MASK;
			svc_en = d[0];
		end
		if (wr && a == `LTE_OFS_STATUS) begin
			cnt = '0;
		end
		@(posedge i_mclk);
		i_psel <= 1'b1;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_mclk);
		i_penable <= 1'b1;
		// Only the bench timeout ends a wait for pready
		do begin
			@(posedge i_mclk);
		end while (o_pready !== 1'b1);
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask

	// ----------------------------------------
	// Output watcher and timeout
	// ----------------------------------------
	always @(posedge i_mclk) begin
		if (o_pready === 1'b1) begin
			ae = (apb_q.size() != 0) ? apb_q.pop_front() : 35'h7_ffff_ffff;
			chk("prdata", o_prdata, ae[31:0]);
			chk("pslverr", {31'h0, o_pslverr}, {31'h0, ae[32]});
			chk("pending", {30'h0, o_critical_pending, o_error_pending},
				{30'h0, ae[34:33]});
		end
		if ((o_error_event | o_critical_event | o_service_event) === 1'b1) begin
			ee = (ev_q.size() != 0) ? ev_q.pop_front() : 3'h0;
			chk("events", {29'h0, o_service_event, o_critical_event, o_error_event},
				{29'h0, ee});
		end
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			finish_test();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge i_mclk);
		i_srst <= 1'b0;
		apb(1'b0, `LTE_OFS_DETECT, '0);
		apb(1'b0, `LTE_OFS_CLASS, '0);
		apb(1'b0, `LTE_OFS_STATUS, '0);
		apb(1'b0, 12'h00c, '0);
		apb(1'b1, 12'h010, 32'hffff_ffff);
		apb(1'b0, 12'h002, '0);
		apb(1'b1, `LTE_OFS_DETECT, 32'hffff_ffff);
		apb(1'b0, `LTE_OFS_DETECT, '0);
		for (int k = 0; k < 27; k++) begin
			fire(27'h1 << k, 1'b0);
			fire(27'h1 << k, 1'b0);
			apb(1'b1, `LTE_OFS_DETECT, 32'hffff_ffff);
			apb(1'b0, `LTE_OFS_DETECT, '0);
			apb(1'b1, `LTE_OFS_DETECT, ~to_flags(27'h1 << k));
			apb(1'b0, `LTE_OFS_DETECT, '0);
		end
		// Critical class and service enable
		apb(1'b1, `LTE_OFS_STATUS, '0);
		apb(1'b1, `LTE_OFS_CLASS, 32'h8000_0001);
		fire(27'h1, 1'b1);
		apb(1'b0, `LTE_OFS_STATUS, '0);
		apb(1'b0, `LTE_OFS_CLASS, '0);
		// Error held high across a zero-write of its flag
		note(27'h1 << 26, 1'b0);
		@(posedge i_mclk);
		src <= 27'h1 << 26;
		apb(1'b1, `LTE_OFS_DETECT, '0);
		src <= '0;
		flags = flags | to_flags(27'h1 << 26);
		apb(1'b0, `LTE_OFS_DETECT, '0);
		for (int i = 0; i < 40; i++) begin
			if (i % 8 == 0) begin
				apb(1'b1, `LTE_OFS_CLASS, $random(seed));
			end
			r = $random(seed) & $random(seed) & $random(seed);
			fire(r[26:0], r[31]);
			if (i % 4 == 3) begin
				r2 = $random(seed);
				apb(1'b0, `LTE_OFS_DETECT, '0);
				apb(1'b0, `LTE_OFS_STATUS, '0);
				apb(1'b1, `LTE_OFS_DETECT, r2);
			end
		end
		apb(1'b0, `LTE_OFS_DETECT, '0);
		repeat (4) @(posedge i_mclk);
		chk("apb_left", 32'(apb_q.size()), '0);
		chk("event_left", 32'(ev_q.size()), '0);
		finish_test();
	end
endmodule
